// [rtl/gwse_edge_status.sv]
// Synchronised edge detector with write-one-to-clear sticky status bits
`timescale 1ns/1ns
`default_nettype none

module gwse_edge_status #(
  parameter int W = 8
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_reset_n,
  input  wire logic [W-1:0] i_pins,
  input  wire logic [W-1:0] i_invert,
  input  wire logic [W-1:0] i_clear,
  output logic      [W-1:0] o_status
);

  logic [W-1:0] sync1_r;
  logic [W-1:0] sync2_r;
  logic [W-1:0] prev_r;
  logic [2:0]   primed_r;
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] status_nxt;

  assign level      = sync2_r ^ i_invert;
  assign rise       = level & ~prev_r & {W{primed_r[2]}};
  assign status_nxt = rise | (o_status & ~i_clear);

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= i_pins;
      sync2_r <= sync1_r;
    end
  end

  // Edges count only once the synchroniser and history hold real pin samples
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      prev_r   <= '0;
      primed_r <= 3'h0;
    end else begin
      prev_r   <= level;
      primed_r <= {primed_r[1:0], 1'b1};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_status <= '0;
    end else begin
      o_status <= status_nxt;
    end
  end

endmodule // gwse_edge_status

`default_nettype wire

// [rtl/gwse_events.sv]
// Wake and system management event collector with output pins and registers
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Each wake pin has its own status and enable bit in sets 1 to 3.
// - Port-1 pins and port-2 pins 3, 4 alone carry management status and enable.
// - Port-4 pins raise neither wake nor management events.
// - Group management irq ORs enabled peripheral and enabled pin events.
// - Management output polarity from bit 2 of polarity config one, default low.
// - Management output is open-drain or push-pull per output type config.
// - Group irq reaches the management pin only with enable set 2 bit 7.
// - Enable set 2 bit 6 places group irq in the serial IRQ2 slot.
// - Pin management status sets on the polarity-selected edge, write one clears.
// - Each pin event's management irq is latched status AND enable.
// - Peripheral status is live, ANDed with enable, not cleared by writes.
// - Wake events come from ring indicator falling edges and wake pin edges.
// - Wake output polarity from bit 5 of polarity config two, default low.
// - Wake output drive type from bit 7 of output type config.
// - Wake output asserts only with global wake enable set.
// - Summary wake status sets on any enabled source regardless of global enable.
// - Summary stays set while enabled sources pend; write one clears source bits.
// - Pin wake status sets on the polarity-selected edge.
// - Runtime registers decode at the block base held in config 0x30.
// - Writing one to summary status clears it when no enabled source pends, and deasserts wake output.
module gwse_events (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_reset_n,
  input  wire gwse_pkg::gwse_bus_req_s    i_bus,
  output logic                     [7:0] o_bus_rdata,
  input  wire logic                [7:0] i_port1_pins,
  input  wire logic                [4:0] i_port2_low_pins,
  input  wire logic                [7:0] i_port3_pins,
  input  wire logic                      i_ring_indicator_a_n,
  input  wire logic                      i_ring_indicator_b_n,
  input  wire gwse_pkg::gwse_periph_irq_s i_periph_irq,
  output logic                           o_sysmgmt_irq_out,
  output logic                           o_sysmgmt_irq_oe_n,
  output logic                           o_wake_event_out,
  output logic                           o_wake_event_oe_n,
  output logic                           o_serirq_irq2
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic cfg_hit(
    input gwse_pkg::gwse_bus_req_s req,
    input logic [7:0]              idx
  );
    cfg_hit = req.cfg_space && (req.addr[15:8] == 8'h00) && (req.addr[7:0] == idx);
  endfunction

  function automatic logic rt_hit(
    input gwse_pkg::gwse_bus_req_s req,
    input logic [7:0]              base
  );
    rt_hit = !req.cfg_space
             && (req.addr[15:12] == gwse_pkg::IO_HIGH_ZERO)
             && (base >= gwse_pkg::RUNTIME_BASE_MIN)
             && (req.addr[11:4] == base);
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] runtime_base_r;
  logic [7:0] polarity_config_one_r;
  logic [7:0] port3_polarity_r;
  logic [7:0] polarity_config_two_r;
  logic [7:0] output_type_config_r;
  logic [7:0] pin_function_r;
  logic       wake_summary_status_r;
  logic       global_wake_enable_r;
  logic [7:0] wake_enable_set1_r;
  logic [6:0] wake_enable_set2_r;
  logic [7:0] wake_enable_set3_r;
  logic [7:0] mgmt_irq_enable_set1_r;
  logic [7:0] mgmt_irq_enable_set2_r;
  logic [7:0] rdata_nxt;
  logic [7:0] rt_rdata;
  logic [7:0] cfg_rdata;

  logic [7:0] wake_status_set1;
  logic [6:0] wake_status_set2;
  logic [7:0] wake_status_set3;
  logic [7:0] mgmt_irq_status_set1;
  logic [1:0] mgmt_pin_status;
  logic [7:0] mgmt_irq_status_set2;

  logic       rt_sel;
  logic       rt_wr;
  logic [3:0] rt_off;
  logic       wake_fire;
  logic       group_sysmgmt_irq;
  logic       smi_pin_selected;

  assign rt_sel = rt_hit(i_bus, runtime_base_r);
  assign rt_wr  = i_bus.wr && rt_sel;
  assign rt_off = i_bus.addr[3:0];

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      runtime_base_r <= gwse_pkg::REG_RESET;
    end else if (i_bus.wr && cfg_hit(i_bus, gwse_pkg::CFG_RUNTIME_BASE)) begin
      runtime_base_r <= i_bus.wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      polarity_config_one_r <= gwse_pkg::REG_RESET;
      port3_polarity_r      <= gwse_pkg::REG_RESET;
      polarity_config_two_r <= gwse_pkg::REG_RESET;
    end else if (i_bus.wr) begin
      if (cfg_hit(i_bus, gwse_pkg::CFG_POLARITY_ONE)) begin
        polarity_config_one_r <= i_bus.wdata;
      end
      if (cfg_hit(i_bus, gwse_pkg::CFG_PORT3_POL)) begin
        port3_polarity_r <= i_bus.wdata;
      end
      if (cfg_hit(i_bus, gwse_pkg::CFG_POLARITY_TWO)) begin
        polarity_config_two_r <= i_bus.wdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      output_type_config_r <= gwse_pkg::REG_RESET;
      pin_function_r       <= gwse_pkg::REG_RESET;
    end else if (i_bus.wr) begin
      if (cfg_hit(i_bus, gwse_pkg::CFG_OUTPUT_TYPE)) begin
        output_type_config_r <= i_bus.wdata;
      end
      if (cfg_hit(i_bus, gwse_pkg::CFG_PIN_FUNCTION)) begin
        pin_function_r <= i_bus.wdata;
      end
    end
  end

  // ----------------------------------------
  // Runtime enable registers
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      global_wake_enable_r <= 1'b0;
      wake_enable_set1_r   <= gwse_pkg::REG_RESET;
      wake_enable_set2_r   <= 7'h00;
      wake_enable_set3_r   <= gwse_pkg::REG_RESET;
    end else if (rt_wr) begin
      unique case (rt_off)
        gwse_pkg::RT_WAKE_GLOBAL: global_wake_enable_r <= i_bus.wdata[0];
        gwse_pkg::RT_WAKE_EN1:    wake_enable_set1_r   <= i_bus.wdata;
        gwse_pkg::RT_WAKE_EN2:    wake_enable_set2_r   <= i_bus.wdata[6:0];
        gwse_pkg::RT_WAKE_EN3:    wake_enable_set3_r   <= i_bus.wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      mgmt_irq_enable_set1_r <= gwse_pkg::REG_RESET;
      mgmt_irq_enable_set2_r <= gwse_pkg::REG_RESET;
    end else if (rt_wr) begin
      if (rt_off == gwse_pkg::RT_MGMT_EN1) begin
        mgmt_irq_enable_set1_r <= i_bus.wdata;
      end
      if (rt_off == gwse_pkg::RT_MGMT_EN2) begin
        mgmt_irq_enable_set2_r <= i_bus.wdata;
      end
    end
  end

  // ----------------------------------------
  // Wake status per source
  // ----------------------------------------
  // Port-4 pins are deliberately not wired to any status set
  gwse_edge_status #(.W(8)) u_wake_set1 (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_pins    (i_port1_pins),
    .i_invert  (polarity_config_one_r),
    .i_clear   ((rt_wr && rt_off == gwse_pkg::RT_WAKE_STS1) ? i_bus.wdata : 8'h00),
    .o_status  (wake_status_set1)
  );

  // Ring indicators are active low, so their falling edge is the event
  gwse_edge_status #(.W(7)) u_wake_set2 (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_pins    ({i_port2_low_pins, i_ring_indicator_b_n, i_ring_indicator_a_n}),
    .i_invert  ({polarity_config_two_r[4:0], 2'b11}),
    .i_clear   ((rt_wr && rt_off == gwse_pkg::RT_WAKE_STS2) ? i_bus.wdata[6:0] : 7'h00),
    .o_status  (wake_status_set2)
  );

  gwse_edge_status #(.W(8)) u_wake_set3 (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_pins    (i_port3_pins),
    .i_invert  (port3_polarity_r),
    .i_clear   ((rt_wr && rt_off == gwse_pkg::RT_WAKE_STS3) ? i_bus.wdata : 8'h00),
    .o_status  (wake_status_set3)
  );

  // ----------------------------------------
  // Management status per pin
  // ----------------------------------------
  gwse_edge_status #(.W(8)) u_mgmt_set1 (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_pins    (i_port1_pins),
    .i_invert  (polarity_config_one_r),
    .i_clear   ((rt_wr && rt_off == gwse_pkg::RT_MGMT_STS1) ? i_bus.wdata : 8'h00),
    .o_status  (mgmt_irq_status_set1)
  );

  gwse_edge_status #(.W(2)) u_mgmt_set2 (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_pins    (i_port2_low_pins[4:3]),
    .i_invert  (polarity_config_two_r[4:3]),
    .i_clear   ((rt_wr && rt_off == gwse_pkg::RT_MGMT_STS2) ?
                {i_bus.wdata[gwse_pkg::M2_P2PIN4_BIT], i_bus.wdata[gwse_pkg::M2_P2PIN3_BIT]} : 2'b00),
    .o_status  (mgmt_pin_status)
  );

  // Peripheral bits are live; writes never touch them
  always_comb begin
    mgmt_irq_status_set2                           = 8'h00;
    mgmt_irq_status_set2[gwse_pkg::M2_PARALLEL_BIT] = i_periph_irq.parallel;
    mgmt_irq_status_set2[gwse_pkg::M2_SERIAL_B_BIT] = i_periph_irq.serial_b;
    mgmt_irq_status_set2[gwse_pkg::M2_SERIAL_A_BIT] = i_periph_irq.serial_a;
    mgmt_irq_status_set2[gwse_pkg::M2_FLOPPY_BIT]   = i_periph_irq.floppy;
    mgmt_irq_status_set2[gwse_pkg::M2_P2PIN3_BIT]   = mgmt_pin_status[0];
    mgmt_irq_status_set2[gwse_pkg::M2_P2PIN4_BIT]   = mgmt_pin_status[1];
  end

  // ----------------------------------------
  // Event combining
  // ----------------------------------------
  assign wake_fire = |(wake_status_set1 & wake_enable_set1_r)
                   | |(wake_status_set2 & wake_enable_set2_r)
                   | |(wake_status_set3 & wake_enable_set3_r);

  assign group_sysmgmt_irq = |(mgmt_irq_status_set1 & mgmt_irq_enable_set1_r)
                           | |(mgmt_irq_status_set2[5:0] & mgmt_irq_enable_set2_r[5:0]);

  assign smi_pin_selected = pin_function_r[gwse_pkg::SMI_PIN_SEL_BIT];

  // Set wins over a clearing write; pending sources hold the summary
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      wake_summary_status_r <= 1'b0;
    end else if (wake_fire) begin
      wake_summary_status_r <= 1'b1;
    end else if (rt_wr && rt_off == gwse_pkg::RT_WAKE_SUMMARY && i_bus.wdata[0]) begin
      wake_summary_status_r <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_serirq_irq2 <= 1'b0;
    end else begin
      o_serirq_irq2 <= group_sysmgmt_irq && mgmt_irq_enable_set2_r[gwse_pkg::M2_SERIRQ_BIT];
    end
  end

  // ----------------------------------------
  // Output pins
  // ----------------------------------------
  gwse_pin_drive u_smi_pin (
    .i_sys_clk     (i_sys_clk),
    .i_reset_n     (i_reset_n),
    .i_enable      (smi_pin_selected),
    .i_active      (group_sysmgmt_irq && mgmt_irq_enable_set2_r[gwse_pkg::M2_PIN_ROUTE_BIT]),
    .i_active_high (polarity_config_one_r[gwse_pkg::SMI_OUT_POL_BIT]),
    .i_push_pull   (output_type_config_r[gwse_pkg::SMI_OUT_TYPE_BIT]),
    .o_pin_out     (o_sysmgmt_irq_out),
    .o_pin_oe_n    (o_sysmgmt_irq_oe_n)
  );

  gwse_pin_drive u_wake_pin (
    .i_sys_clk     (i_sys_clk),
    .i_reset_n     (i_reset_n),
    .i_enable      (1'b1),
    .i_active      (wake_summary_status_r && global_wake_enable_r),
    .i_active_high (polarity_config_two_r[gwse_pkg::WAKE_OUT_POL_BIT]),
    .i_push_pull   (output_type_config_r[gwse_pkg::WAKE_OUT_TYPE_BIT]),
    .o_pin_out     (o_wake_event_out),
    .o_pin_oe_n    (o_wake_event_oe_n)
  );

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    rt_rdata = 8'h00;
    unique case (rt_off)
      gwse_pkg::RT_WAKE_SUMMARY: rt_rdata = {7'h00, wake_summary_status_r};
      gwse_pkg::RT_WAKE_GLOBAL:  rt_rdata = {7'h00, global_wake_enable_r};
      gwse_pkg::RT_WAKE_STS1:    rt_rdata = wake_status_set1;
      gwse_pkg::RT_WAKE_STS2:    rt_rdata = {1'b0, wake_status_set2};
      gwse_pkg::RT_WAKE_STS3:    rt_rdata = wake_status_set3;
      gwse_pkg::RT_WAKE_EN1:     rt_rdata = wake_enable_set1_r;
      gwse_pkg::RT_WAKE_EN2:     rt_rdata = {1'b0, wake_enable_set2_r};
      gwse_pkg::RT_WAKE_EN3:     rt_rdata = wake_enable_set3_r;
      gwse_pkg::RT_MGMT_STS1:    rt_rdata = mgmt_irq_status_set1;
      gwse_pkg::RT_MGMT_STS2:    rt_rdata = mgmt_irq_status_set2;
      gwse_pkg::RT_MGMT_EN1:     rt_rdata = mgmt_irq_enable_set1_r;
      gwse_pkg::RT_MGMT_EN2:     rt_rdata = mgmt_irq_enable_set2_r;
      default:                   rt_rdata = 8'h00;
    endcase
  end

  always_comb begin
    cfg_rdata = 8'h00;
    if (cfg_hit(i_bus, gwse_pkg::CFG_RUNTIME_BASE)) begin
      cfg_rdata = runtime_base_r;
    end else if (cfg_hit(i_bus, gwse_pkg::CFG_POLARITY_ONE)) begin
      cfg_rdata = polarity_config_one_r;
    end else if (cfg_hit(i_bus, gwse_pkg::CFG_PORT3_POL)) begin
      cfg_rdata = port3_polarity_r;
    end else if (cfg_hit(i_bus, gwse_pkg::CFG_POLARITY_TWO)) begin
      cfg_rdata = polarity_config_two_r;
    end else if (cfg_hit(i_bus, gwse_pkg::CFG_OUTPUT_TYPE)) begin
      cfg_rdata = output_type_config_r;
    end else if (cfg_hit(i_bus, gwse_pkg::CFG_PIN_FUNCTION)) begin
      cfg_rdata = pin_function_r;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_bus.rd) begin
      rdata_nxt = rt_sel ? rt_rdata : cfg_rdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_bus_rdata <= 8'h00;
    end else begin
      o_bus_rdata <= rdata_nxt;
    end
  end

endmodule // gwse_events

`default_nettype wire

// [rtl/gwse_pin_drive.sv]
// Registered output pin driver with polarity and open-drain or push-pull choice
`timescale 1ns/1ns
`default_nettype none

module gwse_pin_drive (
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  input  wire logic i_enable,
  input  wire logic i_active,
  input  wire logic i_active_high,
  input  wire logic i_push_pull,
  output logic      o_pin_out,
  output logic      o_pin_oe_n
);

  logic level;

  assign level = i_active ? i_active_high : ~i_active_high;

  // Open drain only ever pulls low; a high level releases the pin
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_pin_out  <= 1'b0;
      o_pin_oe_n <= 1'b1;
    end else if (!i_enable) begin
      o_pin_out  <= 1'b0;
      o_pin_oe_n <= 1'b1;
    end else if (i_push_pull) begin
      o_pin_out  <= level;
      o_pin_oe_n <= 1'b0;
    end else begin
      o_pin_out  <= 1'b0;
      o_pin_oe_n <= level;
    end
  end

endmodule // gwse_pin_drive

`default_nettype wire

// [rtl/gwse_pkg.sv]
// Package of constants and carriers for the wake and management interrupt block
`default_nettype none

package gwse_pkg;

  // ----------------------------------------
  // Configuration indices
  // ----------------------------------------
  localparam logic [7:0] CFG_RUNTIME_BASE  = 8'h30;
  localparam logic [7:0] CFG_POLARITY_ONE  = 8'h32;
  localparam logic [7:0] CFG_PORT3_POL     = 8'h33;
  localparam logic [7:0] CFG_POLARITY_TWO  = 8'h34;
  localparam logic [7:0] CFG_OUTPUT_TYPE   = 8'h39;
  localparam logic [7:0] CFG_PIN_FUNCTION  = 8'h3D;
  localparam logic [7:0] RUNTIME_BASE_MIN  = 8'h10;
  localparam logic [3:0] IO_HIGH_ZERO      = 4'h0;

  // ----------------------------------------
  // Runtime offsets
  // ----------------------------------------
  localparam logic [3:0] RT_WAKE_SUMMARY = 4'h0;
  localparam logic [3:0] RT_WAKE_GLOBAL  = 4'h1;
  localparam logic [3:0] RT_WAKE_STS1    = 4'h2;
  localparam logic [3:0] RT_WAKE_STS2    = 4'h3;
  localparam logic [3:0] RT_WAKE_STS3    = 4'h4;
  localparam logic [3:0] RT_WAKE_EN1     = 4'h5;
  localparam logic [3:0] RT_WAKE_EN2     = 4'h6;
  localparam logic [3:0] RT_WAKE_EN3     = 4'h7;
  localparam logic [3:0] RT_MGMT_STS1    = 4'h8;
  localparam logic [3:0] RT_MGMT_STS2    = 4'h9;
  localparam logic [3:0] RT_MGMT_EN1     = 4'hA;
  localparam logic [3:0] RT_MGMT_EN2     = 4'hB;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int SMI_OUT_POL_BIT   = 2;
  localparam int SMI_OUT_TYPE_BIT  = 2;
  localparam int WAKE_OUT_POL_BIT  = 5;
  localparam int WAKE_OUT_TYPE_BIT = 7;
  localparam int SMI_PIN_SEL_BIT   = 0;
  localparam int M2_PARALLEL_BIT   = 0;
  localparam int M2_SERIAL_B_BIT   = 1;
  localparam int M2_SERIAL_A_BIT   = 2;
  localparam int M2_FLOPPY_BIT     = 3;
  localparam int M2_P2PIN3_BIT     = 4;
  localparam int M2_P2PIN4_BIT     = 5;
  localparam int M2_SERIRQ_BIT     = 6;
  localparam int M2_PIN_ROUTE_BIT  = 7;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic        cfg_space;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } gwse_bus_req_s;

  typedef struct packed {
    logic parallel;
    logic serial_a;
    logic serial_b;
    logic floppy;
  } gwse_periph_irq_s;

endpackage

`default_nettype wire

// [tb/gwse_chipset_model.sv]
// Chipset side of the wake and management lines, with board pull-ups
`timescale 1ns/1ns
`default_nettype none

module gwse_chipset_model (
  input  wire logic i_wake_out,
  input  wire logic i_wake_oe_n,
  input  wire logic i_smi_out,
  input  wire logic i_smi_oe_n,
  output logic      o_wake_line,
  output logic      o_smi_line
);
  // Released lines float to the pull-up level
  assign o_wake_line = i_wake_oe_n ? 1'b1 : i_wake_out;
  assign o_smi_line  = i_smi_oe_n ? 1'b1 : i_smi_out;
endmodule // gwse_chipset_model

`default_nettype wire

// [tb/gwse_events_assertions.sv]
// Port checker of the wake and management event block
`timescale 1ns/1ns
`default_nettype none

module gwse_events_assertions (
  input wire logic                       i_sys_clk,
  input wire logic                       i_reset_n,
  input wire gwse_pkg::gwse_bus_req_s    i_bus,
  input wire logic                 [7:0] o_bus_rdata,
  input wire gwse_pkg::gwse_periph_irq_s i_periph_irq,
  input wire logic                       o_sysmgmt_irq_out,
  input wire logic                       o_sysmgmt_irq_oe_n,
  input wire logic                       o_wake_event_out,
  input wire logic                       o_wake_event_oe_n,
  input wire logic                       o_serirq_irq2
);
  // ------------------------------
  // Shadow of written settings
  // ------------------------------
  logic [7:0] base_r, men2_r;
  logic       gl_r, wpol_r, mpol_r, wpp_r, mpp_r, rt_hit, quiet;
  logic [2:0] q_r;
  assign rt_hit = i_bus.wr && !i_bus.cfg_space && i_bus.addr[15:12] == 4'h0
                  && i_bus.addr[11:4] == base_r && base_r >= 8'h10;
  // Settings take a few cycles to reach the pins
  assign quiet = q_r >= 3'h3;
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      {base_r, men2_r, gl_r, wpol_r, mpol_r, wpp_r, mpp_r} <= '0;
      q_r <= 3'h0;
    end else begin
      q_r <= i_bus.wr ? 3'h0 : q_r + {2'h0, q_r != 3'h7};
      if (i_bus.wr && i_bus.cfg_space) begin
        case (i_bus.addr[7:0])
          gwse_pkg::CFG_RUNTIME_BASE: base_r <= i_bus.wdata;
          gwse_pkg::CFG_POLARITY_ONE: mpol_r <= i_bus.wdata[2];
          gwse_pkg::CFG_POLARITY_TWO: wpol_r <= i_bus.wdata[5];
          gwse_pkg::CFG_OUTPUT_TYPE: {wpp_r, mpp_r} <= {i_bus.wdata[7], i_bus.wdata[2]};
          default: ;
        endcase
      end
      if (rt_hit && i_bus.addr[3:0] == 4'h1) gl_r <= i_bus.wdata[0];
      if (rt_hit && i_bus.addr[3:0] == 4'hB) men2_r <= i_bus.wdata;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  a_rdata_idle: assert property (!$past(i_bus.rd) |-> o_bus_rdata == 8'h00)
    else $error("read data outside its answer cycle");
  a_reset_quiet: assert property (disable iff (1'b0)
    !i_reset_n |=> o_wake_event_oe_n && o_sysmgmt_irq_oe_n && !o_serirq_irq2)
    else $error("pins driven after reset");
  a_wake_level: assert property (quiet && !wpp_r && !o_wake_event_oe_n |-> o_wake_event_out == 1'b0)
    else $error("wake pin driven at wrong level");
  a_wake_type: assert property (quiet && wpp_r |-> !o_wake_event_oe_n)
    else $error("push-pull wake pin released");
  a_wake_gated: assert property (quiet && !gl_r |-> o_wake_event_oe_n || o_wake_event_out != wpol_r)
    else $error("wake asserted with global enable clear");
  a_smi_gated: assert property (quiet && !men2_r[7] |-> o_sysmgmt_irq_oe_n || o_sysmgmt_irq_out != mpol_r)
    else $error("management pin asserted with route off");
  a_smi_level: assert property (quiet && !mpp_r && !o_sysmgmt_irq_oe_n |-> o_sysmgmt_irq_out == 1'b0)
    else $error("management pin driven at wrong level");
  a_serirq_off: assert property (quiet && !men2_r[6] |-> !o_serirq_irq2)
    else $error("serial slot used with route off");
  a_periph_live: assert property ((quiet && men2_r[6] && men2_r[0] && i_periph_irq.parallel) [*6] |-> o_serirq_irq2)
    else $error("enabled peripheral irq not forwarded");

  c_wake: cover property (!o_wake_event_oe_n && o_wake_event_out == wpol_r);
  c_smi: cover property (!o_sysmgmt_irq_oe_n);
  c_serirq: cover property ($rose(o_serirq_irq2));
endmodule // gwse_events_assertions

bind gwse_events gwse_events_assertions u_gwse_chk (
  .i_sys_clk, .i_reset_n, .i_bus, .o_bus_rdata, .i_periph_irq, .o_sysmgmt_irq_out,
  .o_sysmgmt_irq_oe_n, .o_wake_event_out, .o_wake_event_oe_n, .o_serirq_irq2
);

`default_nettype wire

// [tb/gwse_events_tb_top.sv]
// Self-checking bench of the wake and management event block
`timescale 1ns/1ns
`default_nettype none

module gwse_events_tb_top;
  typedef struct packed {logic c; logic [15:0] a; logic [7:0] d; logic [7:0] e;} gwse_row_s;
  logic                       i_sys_clk, i_reset_n;
  gwse_pkg::gwse_bus_req_s    bus;
  gwse_pkg::gwse_periph_irq_s irq;
  logic [7:0]                 rdata, p1, p3;
  logic [4:0]                 p2;
  logic                       ria_n, rib_n, smi_out, smi_oe_n, wk_out, wk_oe_n, sirq, wk_ln, smi_ln;
  int                         err_total = 0, comparisons = 0, cyc = 0;
  gwse_row_s                  rows [8] = '{'{1'b1, 16'h0030, 8'h20, 8'h20}, '{1'b0, 16'h0201, 8'hFF, 8'h01},
    '{1'b0, 16'h0205, 8'hFF, 8'hFF}, '{1'b0, 16'h0206, 8'hFF, 8'h7F}, '{1'b0, 16'h0207, 8'hFF, 8'hFF},
    '{1'b0, 16'h020A, 8'hFF, 8'hFF}, '{1'b0, 16'h020C, 8'hFF, 8'h00}, '{1'b0, 16'h030A, 8'hFF, 8'h00}};

  gwse_events DUT (.i_sys_clk, .i_reset_n, .i_bus(bus), .o_bus_rdata(rdata), .i_port1_pins(p1),
    .i_port2_low_pins(p2), .i_port3_pins(p3), .i_ring_indicator_a_n(ria_n), .i_ring_indicator_b_n(rib_n),
    .i_periph_irq(irq), .o_sysmgmt_irq_out(smi_out), .o_sysmgmt_irq_oe_n(smi_oe_n),
    .o_wake_event_out(wk_out), .o_wake_event_oe_n(wk_oe_n), .o_serirq_irq2(sirq));
  gwse_chipset_model u_chipset (.i_wake_out(wk_out), .i_wake_oe_n(wk_oe_n), .i_smi_out(smi_out),
    .i_smi_oe_n(smi_oe_n), .o_wake_line(wk_ln), .o_smi_line(smi_ln));

  // ------------------------------
  // Clock, timeout and helpers
  // ------------------------------
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      finish_test();
    end
  end
  function automatic logic [15:0] rt(input logic [3:0] o);
    return {4'h0, 8'h20, o};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bw(input logic c, input logic [15:0] a, input logic [7:0] d);
    bus <= '{c, a, d, 1'b1, 1'b0};
    @(posedge i_sys_clk);
    bus.wr <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  task automatic br(input logic c, input logic [15:0] a, input logic [7:0] e);
    bus <= '{c, a, 8'h00, 1'b0, 1'b1};
    @(posedge i_sys_clk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, e);
    @(posedge i_sys_clk);
  endtask
  // Lines: bit2 wake, bit1 management, bit0 serial slot
  task automatic pins(input int n, input logic [7:0] e);
    repeat (n) @(posedge i_sys_clk);
    #1;
    chk({5'h00, wk_ln, smi_ln, sirq}, e);
    @(posedge i_sys_clk);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    {i_reset_n, bus, irq, p1, p2, p3, ria_n, rib_n} = '0;
    {ria_n, rib_n} = 2'b11;
    repeat (16) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    pins(1, 8'h06);
    foreach (rows[i]) begin
      bw(rows[i].c, rows[i].a, rows[i].d);
      br(rows[i].c, rows[i].a, rows[i].e);
    end
    p1 <= 8'h01;
    pins(7, 8'h02);
    br(1'b0, rt(4'h2), 8'h01);
    br(1'b0, rt(4'h8), 8'h01);
    bw(1'b0, rt(4'h0), 8'h01);
    br(1'b0, rt(4'h0), 8'h01);
    bw(1'b0, rt(4'h8), 8'h01);
    bw(1'b0, rt(4'h2), 8'h01);
    bw(1'b0, rt(4'h0), 8'h01);
    pins(3, 8'h06);
    bw(1'b0, rt(4'h1), 8'h00);
    p3 <= 8'h80;
    {ria_n, rib_n} <= 2'b00;
    pins(7, 8'h06);
    br(1'b0, rt(4'h0), 8'h01);
    br(1'b0, rt(4'h4), 8'h80);
    br(1'b0, rt(4'h3), 8'h03);
    bw(1'b1, 16'h0034, 8'h01);
    repeat (6) @(posedge i_sys_clk);
    bw(1'b0, rt(4'h3), 8'hFF);
    p2 <= 5'h01;
    repeat (6) @(posedge i_sys_clk);
    br(1'b0, rt(4'h3), 8'h00);
    p2 <= 5'h00;
    repeat (6) @(posedge i_sys_clk);
    br(1'b0, rt(4'h3), 8'h04);
    bw(1'b1, 16'h003D, 8'h01);
    bw(1'b0, rt(4'hB), 8'h40);
    p1 <= 8'h03;
    pins(7, 8'h07);
    bw(1'b0, rt(4'hB), 8'hC0);
    pins(3, 8'h05);
    bw(1'b0, rt(4'h8), 8'h02);
    pins(3, 8'h06);
    bw(1'b0, rt(4'hB), 8'hC1);
    irq.parallel <= 1'b1;
    pins(6, 8'h05);
    bw(1'b0, rt(4'h9), 8'h01);
    br(1'b0, rt(4'h9), 8'h01);
    irq.parallel <= 1'b0;
    pins(6, 8'h06);
    bw(1'b0, rt(4'hA), 8'hFB);
    bw(1'b1, 16'h0039, 8'h84);
    bw(1'b1, 16'h0034, 8'h21);
    bw(1'b1, 16'h0032, 8'h04);
    pins(3, 8'h00);
    bw(1'b0, rt(4'h1), 8'h01);
    pins(3, 8'h04);
    finish_test();
  end
endmodule // gwse_events_tb_top

`default_nettype wire
